// *** pbi_pkg.sv ***
// package for the processor bus interface block
// assumes a 40 MHz board clock and a synchronous, active-low reset release
package pbi_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int MUX_W = 20;
	localparam int STAT_W = 3;
	localparam int SEL_W = 8;
	// cycle status encodings
	localparam logic [2:0] CST_INTA = 3'h0;
	localparam logic [2:0] CST_IORD = 3'h1;
	localparam logic [2:0] CST_IOWR = 3'h2;
	localparam logic [2:0] CST_HALT = 3'h3;
	localparam logic [2:0] CST_FETCH = 3'h4;
	localparam logic [2:0] CST_MEMRD = 3'h5;
	localparam logic [2:0] CST_MEMWR = 3'h6;
	localparam logic [2:0] CST_IDLE = 3'h7;
	// space select decode uses the top three address bits
	localparam int SEL_HI = 19;
	localparam int SEL_LO = 17;
	// cpu clock: 40 MHz / 4.9152 MHz -> nco phase accumulator
	localparam int CLK_HZ = 40000000;
	localparam int CPU_CLK_HZ = 4915200;
	localparam int NCO_W = 16;
	localparam logic [NCO_W-1:0] NCO_INC =
		NCO_W'((64'(CPU_CLK_HZ) << NCO_W) / 64'(CLK_HZ));
	// bus clock divider, half period in board clocks
	localparam int BCLK_HALF_NS = 50;
	localparam int CLK_NS = 25;
	localparam logic [3:0] BCLK_HALF = 4'(BCLK_HALF_NS / CLK_NS);
	localparam logic [3:0] BCLK_ONE = 4'h1;
	// timeout counter width
	localparam int TO_W = 16;
	localparam logic [TO_W-1:0] TO_DEF = 16'h0100;
endpackage

// *** pbi_bridge.sv ***
// processor bus interface: demultiplexes the cpu bus, decodes status,
// grants the system bus and completes unacknowledged commands.
// assumes the cpu drives status 3'h7 outside T1..Tw and that the
// interval timer supplies the timeout count; one clock domain.
//
// Behaviour
// - the muxed lines split into 20-bit local address and 16-bit data.
// - the same address and data are presented on the system buses.
// - cycle status is decoded into one strobe per type and paces cycles.
// - a command that no slave acknowledges is detected.
// - on that event the block drives its own ack and sets an error bit.
// - the timeout length is the interval given by the interval timer.
// - high address bits are decoded into space select lines.
// - bus use is granted together with backplane priority logic.
// - board status is readable and its read strobe clears the timeout error bit.
// - a 4.9152 MHz cpu clock is made; cpu reset and ready are synced.
// - a shared bus clock is produced.
// - the address is captured when status becomes valid.
`timescale 1ns/1ps
module pbi_bridge
	import pbi_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic clk_en,
	// cpu side
	input wire logic [pbi_pkg::MUX_W-1:0] muxed_addr_data_in,
	output logic [pbi_pkg::MUX_W-1:0] muxed_addr_data_out,
	output logic muxed_addr_data_oe,
	input wire logic [pbi_pkg::STAT_W-1:0] cycle_status,
	input wire logic cpu_reset_req,
	input wire logic cpu_ready_req,
	output logic cpu_clk,
	output logic cpu_reset,
	output logic cpu_ready,
	// local buses
	output logic [pbi_pkg::ADDR_W-1:0] local_addr_bus,
	output logic [pbi_pkg::DATA_W-1:0] local_data_bus,
	input wire logic [pbi_pkg::DATA_W-1:0] local_data_in,
	input wire logic local_ack,
	// system buses
	output logic [pbi_pkg::ADDR_W-1:0] system_addr_bus,
	output logic [pbi_pkg::DATA_W-1:0] system_data_out,
	output logic system_data_oe,
	input wire logic [pbi_pkg::DATA_W-1:0] system_data_in,
	input wire logic slave_ack_primary_in,
	input wire logic slave_ack_secondary_in,
	output logic slave_ack_primary_out,
	output logic slave_ack_primary_oe,
	output logic slave_ack_secondary_out,
	output logic slave_ack_secondary_oe,
	output logic bus_clk,
	// status decode
	output logic cyc_inta,
	output logic cyc_iord,
	output logic cyc_iowr,
	output logic cyc_halt,
	output logic cyc_fetch,
	output logic cyc_memrd,
	output logic cyc_memwr,
	output logic cyc_idle,
	output logic [pbi_pkg::SEL_W-1:0] space_sel,
	// bus arbitration
	input wire logic bus_priority_ok,
	input wire logic bus_busy_in,
	output logic bus_request,
	output logic bus_busy_out,
	output logic bus_granted,
	// timeout and status
	input wire logic [pbi_pkg::TO_W-1:0] timeout_interval,
	input wire logic status_read_strobe,
	input wire logic timeout_err_clr,
	input wire logic [1:0] board_status_in,
	output logic [1:0] board_status,
	output logic timeout_err
);
	import pbi_pkg::*;

	typedef enum logic [3:0] {
		PBI_IDLE = 4'h1,
		PBI_ADDR = 4'h2,
		PBI_DATA = 4'h4,
		PBI_DONE = 4'h8
	} pbi_state_t;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// true when status names a bus transfer
	function automatic logic pbi_is_xfer(input logic [2:0] s);
		return (s != CST_IDLE) && (s != CST_HALT);
	endfunction

	// true when status names a read towards the cpu
	function automatic logic pbi_is_read(input logic [2:0] s);
		return (s == CST_IORD) || (s == CST_MEMRD) ||
			(s == CST_FETCH) || (s == CST_INTA);
	endfunction

	// ---------------------------------------------------------------
	// clocks and synchronisers
	// ---------------------------------------------------------------
	logic [NCO_W-1:0] nco_r, nco_nxt;
	logic [3:0] bdiv_r, bdiv_nxt;
	logic bclk_r, bclk_nxt;
	logic [1:0] rst_sync_r, rst_sync_nxt;
	logic [1:0] rdy_sync_r, rdy_sync_nxt;

	// nco and bus clock divider, two-stage syncs
	always_comb begin
		nco_nxt = nco_r + NCO_INC;
		rst_sync_nxt = {rst_sync_r[0], cpu_reset_req};
		rdy_sync_nxt = {rdy_sync_r[0], cpu_ready_req};
		bdiv_nxt = bdiv_r - BCLK_ONE;
		bclk_nxt = bclk_r;
		if (bdiv_r == BCLK_ONE) begin
			bdiv_nxt = BCLK_HALF;
			bclk_nxt = ~bclk_r;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			nco_r <= '0;
			bdiv_r <= BCLK_HALF;
			bclk_r <= 1'b0;
			rst_sync_r <= 2'h3;
			rdy_sync_r <= 2'h0;
		end else if (clk_en) begin
			nco_r <= nco_nxt;
			bdiv_r <= bdiv_nxt;
			bclk_r <= bclk_nxt;
			rst_sync_r <= rst_sync_nxt;
			rdy_sync_r <= rdy_sync_nxt;
		end
	end

	assign cpu_clk = nco_r[NCO_W-1];
	assign bus_clk = bclk_r;
	assign cpu_reset = rst_sync_r[1];

	// ---------------------------------------------------------------
	// cycle tracking, address latch, timeout
	// ---------------------------------------------------------------
	pbi_state_t st_r, st_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [DATA_W-1:0] wdat_r, wdat_nxt, rdat_r, rdat_nxt;
	logic [2:0] cst_r, cst_nxt;
	logic [TO_W-1:0] to_cnt_r, to_cnt_nxt;
	logic err_r, err_nxt, own_ack_r, own_ack_nxt;
	logic [1:0] bstat_r, bstat_nxt;
	logic is_local, any_ack, to_hit, grant;

	assign is_local = (addr_r[SEL_HI:SEL_LO] == '0);
	assign any_ack = slave_ack_primary_in | slave_ack_secondary_in;
	assign grant = bus_priority_ok & ~bus_busy_in;
	assign to_hit = (st_r == PBI_DATA) && !is_local && grant &&
		!any_ack && (to_cnt_r >= timeout_interval);

	// cycle state machine
	always_comb begin
		st_nxt = st_r;
		addr_nxt = addr_r;
		wdat_nxt = wdat_r;
		rdat_nxt = rdat_r;
		cst_nxt = cst_r;
		to_cnt_nxt = to_cnt_r;
		own_ack_nxt = 1'b0;
		bstat_nxt = status_read_strobe ? board_status_in : bstat_r;
		err_nxt = err_r;
		// a status read clears the error, as does an explicit clear
		if (timeout_err_clr || status_read_strobe)
			err_nxt = 1'b0;
		if (to_hit)
			err_nxt = 1'b1; // set wins over clear
		case (st_r)
			PBI_IDLE: begin
				if (pbi_is_xfer(cycle_status)) begin
					addr_nxt = muxed_addr_data_in;
					cst_nxt = cycle_status;
					to_cnt_nxt = '0;
					st_nxt = PBI_ADDR;
				end
			end
			PBI_ADDR: begin
				st_nxt = PBI_DATA; // data phase follows address
			end
			PBI_DATA: begin
				if (!pbi_is_read(cst_r))
					wdat_nxt = muxed_addr_data_in[DATA_W-1:0];
				if (is_local) begin
					if (local_ack) begin
						rdat_nxt = local_data_in;
						st_nxt = PBI_DONE;
					end
				end else if (grant) begin
					if (any_ack) begin
						rdat_nxt = system_data_in;
						st_nxt = PBI_DONE;
					end else if (to_hit) begin
						own_ack_nxt = 1'b1;
						rdat_nxt = '1;
						st_nxt = PBI_DONE;
					end else begin
						to_cnt_nxt = to_cnt_r + 1'b1;
					end
				end
			end
			PBI_DONE: begin
				if (cycle_status == CST_IDLE)
					st_nxt = PBI_IDLE; // waits for inactive status
			end
			default: st_nxt = PBI_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= PBI_IDLE;
			addr_r <= '0;
			wdat_r <= '0;
			rdat_r <= '0;
			cst_r <= CST_IDLE;
			to_cnt_r <= '0;
			err_r <= 1'b0;
			own_ack_r <= 1'b0;
			bstat_r <= 2'h0;
		end else if (clk_en) begin
			st_r <= st_nxt;
			addr_r <= addr_nxt;
			wdat_r <= wdat_nxt;
			rdat_r <= rdat_nxt;
			cst_r <= cst_nxt;
			to_cnt_r <= to_cnt_nxt;
			err_r <= err_nxt;
			own_ack_r <= own_ack_nxt;
			bstat_r <= bstat_nxt;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// bus copies of the latched address and data
	assign local_addr_bus = addr_r;
	assign system_addr_bus = addr_r;
	assign local_data_bus = pbi_is_read(cst_r) ? rdat_r : wdat_r;
	assign system_data_out = wdat_r;
	assign system_data_oe = (st_r == PBI_DATA) && !is_local &&
		!pbi_is_read(cst_r) && grant;
	assign muxed_addr_data_out = {{(MUX_W-DATA_W){1'b0}}, rdat_r};
	assign muxed_addr_data_oe = (st_r == PBI_DONE) && pbi_is_read(cst_r);
	assign cpu_ready = rdy_sync_r[1] & (st_r == PBI_DONE);
	// own acknowledge drives both ack lines for one cycle
	assign slave_ack_primary_out = own_ack_r;
	assign slave_ack_primary_oe = own_ack_r;
	assign slave_ack_secondary_out = own_ack_r;
	assign slave_ack_secondary_oe = own_ack_r;
	// decode one strobe per status code
	assign cyc_inta = (cycle_status == CST_INTA);
	assign cyc_iord = (cycle_status == CST_IORD);
	assign cyc_iowr = (cycle_status == CST_IOWR);
	assign cyc_halt = (cycle_status == CST_HALT);
	assign cyc_fetch = (cycle_status == CST_FETCH);
	assign cyc_memrd = (cycle_status == CST_MEMRD);
	assign cyc_memwr = (cycle_status == CST_MEMWR);
	assign cyc_idle = (cycle_status == CST_IDLE);
	assign space_sel = (st_r == PBI_IDLE) ? '0 :
		SEL_W'(1) << addr_r[SEL_HI:SEL_LO];
	assign bus_request = (st_r != PBI_IDLE) && !is_local;
	assign bus_busy_out = bus_request && grant;
	assign bus_granted = grant;
	assign board_status = bstat_r;
	assign timeout_err = err_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_timeout;
		to_hit && clk_en;
	endsequence

	chk_err_on_timeout: assert property (
		@(posedge clk) disable iff (!nrst)
		s_timeout |=> timeout_err) else $error("err not set");
	chk_own_ack: assert property (
		@(posedge clk) disable iff (!nrst)
		s_timeout |=> slave_ack_primary_oe && slave_ack_secondary_oe)
		else $error("no own ack");
	chk_err_sticky: assert property (
		@(posedge clk) disable iff (!nrst)
		timeout_err && !timeout_err_clr && !status_read_strobe |=>
		timeout_err) else $error("err dropped");
	chk_addr_latch: assert property (
		@(posedge clk) disable iff (!nrst)
		clk_en && st_r == PBI_IDLE && pbi_is_xfer(cycle_status) |=>
		local_addr_bus == $past(muxed_addr_data_in) &&
		system_addr_bus == local_addr_bus)
		else $error("addr not latched");
	chk_no_early_to: assert property (
		@(posedge clk) disable iff (!nrst)
		clk_en && st_r == PBI_DATA && !any_ack &&
		to_cnt_r < timeout_interval |=>
		!slave_ack_primary_oe && !slave_ack_secondary_oe)
		else $error("early timeout");
	chk_sel_onehot: assert property (
		@(posedge clk) disable iff (!nrst)
		st_r != PBI_IDLE |-> $onehot(space_sel))
		else $error("bad space select");
	chk_busy_grant: assert property (
		@(posedge clk) disable iff (!nrst)
		bus_busy_out |-> bus_priority_ok && !bus_busy_in)
		else $error("bus used without grant");
	chk_status_dec: assert property (
		@(posedge clk) disable iff (!nrst)
		$onehot({cyc_inta, cyc_iord, cyc_iowr, cyc_halt, cyc_fetch,
		cyc_memrd, cyc_memwr, cyc_idle}))
		else $error("status decode");
endmodule

// *** pbi_slave_model.sv ***
// system bus slave standing on the far side of the bus interface
// assumes the bridge grants the bus and holds status until the cycle ends
`timescale 1ns/1ps
module pbi_slave_model
	import pbi_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// bus side
	input wire logic bus_granted,
	input wire logic [pbi_pkg::STAT_W-1:0] cycle_status,
	input wire logic [pbi_pkg::ADDR_W-1:0] system_addr_bus,
	output logic [pbi_pkg::DATA_W-1:0] system_data,
	output logic ack_p,
	output logic ack_s,
	// scenario control
	input wire logic [3:0] dly,
	input wire logic mute,
	input wire logic use_sec
);
	import pbi_pkg::*;

	logic [3:0] cnt_r;
	logic ack_r;
	logic [pbi_pkg::DATA_W-1:0] last_r;
	logic busy;
	assign busy = bus_granted && (cycle_status != CST_IDLE);
	// wait dly granted cycles, then hold the ack until status goes idle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 4'h0;
			ack_r <= 1'b0;
			last_r <= 16'h0000;
		end else begin
			last_r <= system_data;
			if (busy && !mute && cnt_r == dly) begin
				ack_r <= 1'b1;
			end else if (busy && !mute) begin
				cnt_r <= cnt_r + 4'h1;
			end else begin
				cnt_r <= 4'h0;
				ack_r <= 1'b0;
			end
		end
	end
	assign ack_p = ack_r && !use_sec;
	assign ack_s = ack_r && use_sec;
	// released lines flip every cycle so a stale value never looks valid
	assign system_data = ack_r ? (system_addr_bus[15:0] ^ 16'h5a5a) : ~last_r;
endmodule

// *** processor_bus_interface_tb.sv ***
// self-checking bench for the processor bus interface
// assumes pbi_pkg, pbi_bridge and pbi_slave_model are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
	$display("BAD t=%0t got %h exp %h", $time, a, b); end end
module processor_bus_interface_tb;
	import pbi_pkg::*;
	typedef struct {logic [2:0] st; logic [19:0] a; logic [15:0] wd;
		logic [7:0] cyc; logic [7:0] sel;} pbi_row_t;
	int err_total = 0;
	int cmp_count = 0;
	int cycles = 0;
	int rises;
	logic clk = 0, nrst = 0, rst_req = 1, lack = 0, prio_ok = 1, mute = 0;
	logic sts_stb = 0, err_clr = 0, use_sec = 0, b, mux_oe, cpu_clk;
	logic cpu_reset, cpu_ready, sdoe, ackp_out, ackp_oe, acks_out, acks_oe;
	logic bus_clk, breq, busy_out, granted, terr, mp, ms, ackp_in, acks_in;
	logic [2:0] cst = CST_IDLE;
	logic [3:0] dly = 4'h0;
	logic [19:0] mux_in = 20'h00000, mux_out, laddr, saddr;
	logic [15:0] ldata, ldin = 16'h0000, sdout, sdin, to_int = 16'h0010;
	logic [7:0] cyc, sel;
	logic [1:0] bst_in = 2'h0, bst;
	pbi_row_t rows [8] = '{
		'{CST_INTA, 20'h00010, 16'h0000, 8'h01, 8'h01},
		'{CST_IORD, 20'h20044, 16'h0000, 8'h02, 8'h02},
		'{CST_IOWR, 20'h00046, 16'hbeef, 8'h04, 8'h01},
		'{CST_FETCH, 20'hfff00, 16'h0000, 8'h10, 8'h80},
		'{CST_MEMRD, 20'h6abcd, 16'h0000, 8'h20, 8'h08},
		'{CST_MEMWR, 20'ha1234, 16'hc0de, 8'h40, 8'h20},
		'{CST_HALT, 20'h00000, 16'h0000, 8'h08, 8'h00},
		'{CST_IDLE, 20'h00000, 16'h0000, 8'h80, 8'h00}};
	logic cyc_idle, cyc_memwr, cyc_memrd, cyc_fetch, cyc_halt;
	logic cyc_iowr, cyc_iord, cyc_inta;
	logic cen = 1'b1, rdy_req = 1'b1, busy_in = 1'b0;
	assign cyc = {cyc_idle, cyc_memwr, cyc_memrd, cyc_fetch, cyc_halt,
		cyc_iowr, cyc_iord, cyc_inta};
	// ack wires: far side or our own timeout ack pulls the line
	assign ackp_in = mp | (ackp_oe & ackp_out);
	assign acks_in = ms | (acks_oe & acks_out);
	pbi_bridge dut_u (.clk(clk), .nrst(nrst), .clk_en(cen),
		.muxed_addr_data_in(mux_in), .muxed_addr_data_out(mux_out),
		.muxed_addr_data_oe(mux_oe), .cycle_status(cst),
		.cpu_reset_req(rst_req), .cpu_ready_req(rdy_req), .cpu_clk(cpu_clk),
		.cpu_reset(cpu_reset), .cpu_ready(cpu_ready),
		.local_addr_bus(laddr), .local_data_bus(ldata),
		.local_data_in(ldin), .local_ack(lack), .system_addr_bus(saddr),
		.system_data_out(sdout), .system_data_oe(sdoe),
		.system_data_in(sdin), .slave_ack_primary_in(ackp_in),
		.slave_ack_secondary_in(acks_in), .slave_ack_primary_out(ackp_out),
		.slave_ack_primary_oe(ackp_oe), .slave_ack_secondary_out(acks_out),
		.slave_ack_secondary_oe(acks_oe), .bus_clk(bus_clk),
		.cyc_inta(cyc_inta), .cyc_iord(cyc_iord), .cyc_iowr(cyc_iowr),
		.cyc_halt(cyc_halt), .cyc_fetch(cyc_fetch), .cyc_memrd(cyc_memrd),
		.cyc_memwr(cyc_memwr), .cyc_idle(cyc_idle), .space_sel(sel),
		.bus_priority_ok(prio_ok), .bus_busy_in(busy_in), .bus_request(breq),
		.bus_busy_out(busy_out), .bus_granted(granted),
		.timeout_interval(to_int), .status_read_strobe(sts_stb),
		.timeout_err_clr(err_clr), .board_status_in(bst_in),
		.board_status(bst), .timeout_err(terr));
	pbi_slave_model slave_u (.clk(clk), .nrst(nrst), .bus_granted(granted),
		.cycle_status(cst), .system_addr_bus(saddr), .system_data(sdin),
		.ack_p(mp), .ack_s(ms), .dly(dly), .mute(mute), .use_sec(use_sec));
	// board clock and hang guard
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (err_total == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// one whole bus cycle as the cpu runs it, from T1 to idle
	task automatic run_cycle(input logic [2:0] st, input logic [19:0] a,
		input logic [15:0] wd, input int stall, input logic [7:0] esel);
		logic wr, loc, own, dro, req;
		logic [15:0] rd;
		int n;
		wr = (st == CST_IOWR) || (st == CST_MEMWR);
		loc = (a[19:17] == 3'h0);
		rd = mute ? 16'hffff : (a[15:0] ^ 16'h5a5a);
		own = 1'b0;
		dro = 1'b0;
		req = 1'b0;
		n = 0;
		prio_ok = (stall == 0);
		ldin = a[15:0] ^ 16'h5a5a;
		cst = st;
		mux_in = a;
		@(negedge clk);
		`CHK(laddr, a)
		`CHK(saddr, a)
		`CHK(sel, esel)
		mux_in = wr ? {4'h0, wd} : ~a;
		for (int k = 0; k < stall; k++) begin
			@(negedge clk);
			`CHK({cpu_ready, terr, granted, busy_out, breq}, 5'b00001)
			if (k == 3) begin
				// priority says yes, but another master holds the bus
				prio_ok = 1'b1;
				busy_in = 1'b1;
			end
		end
		prio_ok = 1'b1;
		busy_in = 1'b0;
		lack = loc;
		while (cpu_ready !== 1'b1 && n < 60) begin
			@(negedge clk);
			own = own | ackp_oe | acks_oe;
			dro = dro | sdoe;
			req = req | busy_out;
			n++;
		end
		@(negedge clk);
		own = own | ackp_oe | acks_oe;
		`CHK(cpu_ready, 1'b1)
		`CHK(own, mute)
		`CHK(terr, mute)
		if (wr && loc) `CHK(ldata, wd)
		if (wr && !loc) `CHK(sdout, wd)
		if (!wr) `CHK({mux_oe, mux_out[15:0]}, {1'b1, rd})
		`CHK(dro, wr && !loc)
		`CHK(req, !loc)
		lack = 1'b0;
		cst = CST_IDLE;
		mux_in = ~mux_in;
		repeat (2) @(negedge clk);
		`CHK(sel, 8'h00)
	endtask
	initial begin
		// reset and clocks
		repeat (16) @(negedge clk);
		`CHK({cpu_reset, terr, bus_clk, laddr}, {3'b100, 20'h0})
		nrst = 1'b1;
		rst_req = 1'b0;
		repeat (4) @(negedge clk);
		`CHK(cpu_reset, 1'b0)
		b = bus_clk;
		repeat (2) @(negedge clk);
		`CHK(bus_clk, ~b)
		rises = 0;
		for (int i = 0; i < 1000; i++) begin
			b = cpu_clk;
			@(negedge clk);
			if (!b && cpu_clk) rises++;
		end
		`CHK((rises >= 122 && rises <= 123), 1'b1)
		// table of status codes, local and system spaces
		foreach (rows[i]) begin
			@(negedge clk);
			dly = (i % 2) ? 4'h6 : 4'h0;
			use_sec = i[1];
			cst = rows[i].st;
			mux_in = rows[i].a;
			#1;
			`CHK(cyc, rows[i].cyc)
			if (rows[i].st == CST_HALT || rows[i].st == CST_IDLE) begin
				@(negedge clk);
				cst = CST_IDLE;
			end else begin
				run_cycle(rows[i].st, rows[i].a, rows[i].wd, 0, rows[i].sel);
			end
		end
		// no grant for longer than the timeout interval
		to_int = 16'h0004;
		dly = 4'h1;
		@(negedge clk);
		run_cycle(CST_MEMWR, 20'h80002, 16'h1234, 8, 8'h10);
		// nobody answers: own ack, error bit, sticky until cleared
		mute = 1'b1;
		@(negedge clk);
		run_cycle(CST_MEMRD, 20'h40010, 16'h0000, 0, 8'h04);
		mute = 1'b0;
		repeat (5) @(negedge clk);
		`CHK(terr, 1'b1)
		err_clr = 1'b1;
		@(negedge clk);
		err_clr = 1'b0;
		@(negedge clk);
		`CHK(terr, 1'b0)
		// a status read also clears a fresh timeout error
		mute = 1'b1;
		@(negedge clk);
		run_cycle(CST_MEMRD, 20'h40010, 16'h0000, 0, 8'h04);
		mute = 1'b0;
		sts_stb = 1'b1;
		@(negedge clk);
		sts_stb = 1'b0;
		@(negedge clk);
		`CHK(terr, 1'b0)
		// board status capture on the read strobe
		bst_in = 2'h2;
		sts_stb = 1'b1;
		@(negedge clk);
		sts_stb = 1'b0;
		bst_in = 2'h1;
		@(negedge clk);
		`CHK(bst, 2'h2)
		// ready request reaches the cpu only through the synchroniser
		rdy_req = 1'b0;
		lack = 1'b1;
		ldin = 16'h1111;
		cst = CST_MEMRD;
		mux_in = 20'h00020;
		repeat (4) @(negedge clk);
		`CHK({cpu_ready, mux_oe}, 2'b01)
		rdy_req = 1'b1;
		@(negedge clk);
		`CHK(cpu_ready, 1'b0)
		@(negedge clk);
		`CHK(cpu_ready, 1'b1)
		lack = 1'b0;
		cst = CST_IDLE;
		repeat (2) @(negedge clk);
		// clock enable low: no cycle is taken and the bus clock stops
		cen = 1'b0;
		b = bus_clk;
		cst = CST_MEMRD;
		mux_in = 20'h40000;
		repeat (2) @(negedge clk);
		`CHK({bus_clk, sel, laddr}, {b, 8'h00, 20'h00020})
		cst = CST_IDLE;
		cen = 1'b1;
		@(negedge clk);
		// second reset in mid-run clears the latched state
		nrst = 1'b0;
		@(negedge clk);
		`CHK({cpu_reset, bst, laddr}, {1'b1, 2'h0, 20'h0})
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		`CHK(cpu_reset, 1'b0)
		end_sim();
	end
endmodule
